// >>> rtl/position_servo_bridge_control.sv
// Position servo H-bridge control: drive states, timeout, protections, clamp
`timescale 1ns/100ps
//
// Behaviour
// - 14-bit timeout, 16384 oscillator periods
// - Leaving rest zone starts motor and timer
// - Stop at zero crossing or timeout
// - Zero crossing brakes with zero differential
// - Inside rest zone both terminals high
// - Error sign sets drive polarity
// - Proportional: one high, other PWM switched
// - Keep residual drive until zero reached
// - Feedback bias sets direction threshold
// - Over-voltage puts bridge in high impedance
// - Over-temperature puts bridge in high impedance
// - Per-transistor current limit, resume after
// - Fast transient clamps via all four
// - Clamp 70V default; overvoltage starts timers
// - Evaluation expiry latches clamp activity
// - Active clamp held until hold expiry
// - Clamp unreached at evaluation raises level
// - Re-arm only below over-voltage threshold
// - Switch delays and timeout from oscillator period, clamp delays in clock cycles
module position_servo_bridge_control #(
	parameter int OSC_CYCLES = servo_bridge_pkg::OSC_CYC,
	parameter int EVAL_CYCLES = servo_bridge_pkg::EVAL_CYC,
	parameter int HOLD_CYCLES = servo_bridge_pkg::HOLD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Analog comparator results, asynchronous
	input wire logic out_of_rest,
	input wire logic error_positive,
	input wire logic below_prop,
	input wire logic zero_cross_comparator,
	input wire logic pwm_compare,
	input wire logic overvoltage,
	input wire logic thermal_shutdown_level,
	input wire logic clamp_active,
	input wire logic [3:0] over_current,
	// Bridge gate drives, terminal levels and enables, clamp and timeout status
	output logic [3:0] gate_on,
	output logic drv_pos_out,
	output logic drv_pos_oe,
	output logic drv_neg_out,
	output logic drv_neg_oe,
	output logic clamp_all_on,
	output logic clamp_high,
	output logic timed_out
);
	import servo_bridge_pkg::*;

	localparam int NSYNC = 8;
	localparam logic [13:0] TOUT_LAST = 14'(TOUT_PERIODS - 1);

	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [3:0] oc_s1_q;
	logic [3:0] oc_s2_q;
	logic s_out_rest, s_pos, s_prop, s_zero, s_pwm, s_ov, s_ot, s_clamp;

	// Two-stage synchronisers for every comparator
	assign async_in = {clamp_active, thermal_shutdown_level, overvoltage, pwm_compare,
		zero_cross_comparator, below_prop, error_positive, out_of_rest};
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			oc_s1_q <= 4'h0;
			oc_s2_q <= 4'h0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			oc_s1_q <= over_current;
			oc_s2_q <= oc_s1_q;
		end
	end
	assign s_out_rest = s2_q[0];
	assign s_pos = s2_q[1]; // Comparator is referenced to feedback bias
	assign s_prop = s2_q[2];
	assign s_zero = s2_q[3];
	assign s_pwm = s2_q[4];
	assign s_ov = s2_q[5];
	assign s_ot = s2_q[6];
	assign s_clamp = s2_q[7];

	// Oscillator period tick
	logic [31:0] osc_cnt_q;
	logic osc_tick;
	assign osc_tick = (osc_cnt_q == 32'(OSC_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (!rst_n)
			osc_cnt_q <= 32'h0000_0000;
		else if (osc_tick)
			osc_cnt_q <= 32'h0000_0000;
		else
			osc_cnt_q <= osc_cnt_q + 32'h0000_0001;
	end

	// Drive state machine
	drive_e st_q, st_d;
	logic [13:0] tout_q;
	logic tout_run_q;
	logic dir_q;
	logic tout_hit;
	assign tout_hit = tout_run_q && osc_tick && (tout_q == TOUT_LAST);

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_REST: begin
				if (s_out_rest)
					st_d = ST_RUN;
			end
			ST_RUN, ST_PROP: begin
				if (s_zero || tout_hit)
					st_d = ST_BRAKE;
				else if (s_prop)
					st_d = ST_PROP;
				else
					st_d = ST_RUN;
			end
			ST_BRAKE: begin
				if (!s_out_rest)
					st_d = ST_REST;
			end
			default: st_d = ST_REST;
		endcase
		if (s_ov || s_ot)
			st_d = ST_OFF;
		else if (st_q == ST_OFF)
			st_d = ST_REST;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_q <= ST_REST;
		else
			st_q <= st_d;
	end

	// Direction latched at start of a move
	always_ff @(posedge clk) begin
		if (!rst_n)
			dir_q <= 1'b0;
		else if (st_q == ST_REST && st_d == ST_RUN)
			dir_q <= s_pos;
	end

	// Timeout counter, one step per oscillator period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tout_q <= 14'h0000;
			tout_run_q <= 1'b0;
			timed_out <= 1'b0;
		end else if (st_q == ST_REST && st_d == ST_RUN) begin
			tout_q <= 14'h0000;
			tout_run_q <= 1'b1;
			timed_out <= 1'b0;
		end else if (tout_hit) begin
			tout_run_q <= 1'b0;
			timed_out <= 1'b1;
		end else if (tout_run_q && osc_tick) begin
			tout_q <= tout_q + 14'h0001;
		end
		if (rst_n && st_d != ST_RUN && st_d != ST_PROP && !(st_q == ST_REST && st_d == ST_RUN))
			tout_run_q <= 1'b0;
	end

	// Desired terminal levels: 1 high, 0 low
	logic want_pos, want_neg, want_oe;
	always_comb begin
		want_pos = 1'b1;
		want_neg = 1'b1;
		want_oe = 1'b1;
		case (st_q)
			ST_RUN: begin
				want_pos = dir_q;
				want_neg = !dir_q;
			end
			ST_PROP: begin
				// Driven side held high, other side switched
				want_pos = dir_q ? 1'b1 : s_pwm;
				want_neg = dir_q ? s_pwm : 1'b1;
			end
			ST_OFF: want_oe = 1'b0;
			default: begin
				want_pos = 1'b1;
				want_neg = 1'b1;
			end
		endcase
	end

	// Switch delay: change applied on the second tick boundary
	logic [2:0] want_q;
	logic [1:0] dly_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			want_q <= 3'b011;
			dly_q <= 2'b00;
		end else if ({want_oe, want_pos, want_neg} != want_q && dly_q == 2'b00) begin
			dly_q <= 2'(SW_DELAY_TICKS);
		end else if (dly_q != 2'b00 && osc_tick) begin
			dly_q <= dly_q - 2'b01;
			if (dly_q == 2'b01)
				want_q <= {want_oe, want_pos, want_neg};
		end
	end

	// Clamp discrimination between fast and slow transients
	clamp_e cl_q;
	logic [31:0] eval_q, hold_q;
	logic eval_done, hold_done;
	assign eval_done = (eval_q == 32'(EVAL_CYCLES - 1));
	assign hold_done = (hold_q == 32'(HOLD_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cl_q <= CL_ARMED;
			eval_q <= 32'h0000_0000;
			hold_q <= 32'h0000_0000;
			clamp_high <= CLAMP_HIGH_RST;
		end else begin
			case (cl_q)
				CL_ARMED: begin
					eval_q <= 32'h0000_0000;
					hold_q <= 32'h0000_0000;
					if (s_ov)
						cl_q <= CL_EVAL;
				end
				CL_EVAL: begin
					eval_q <= eval_q + 32'h0000_0001;
					hold_q <= hold_q + 32'h0000_0001;
					if (eval_done) begin
						if (s_clamp) begin
							cl_q <= CL_HOLD;
						end else begin
							cl_q <= CL_RAISED;
							clamp_high <= 1'b1;
						end
					end
				end
				CL_HOLD: begin
					hold_q <= hold_q + 32'h0000_0001;
					if (hold_done) begin
						cl_q <= CL_RAISED;
						clamp_high <= 1'b1;
					end
				end
				CL_RAISED: begin
					if (!s_ov) begin
						cl_q <= CL_ARMED;
						clamp_high <= 1'b0;
					end
				end
				default: cl_q <= CL_ARMED;
			endcase
		end
	end

	// Gate drives: clamp overrides, current limit per transistor
	logic [3:0] gate_d;
	logic clamp_now;
	assign clamp_now = s_clamp && !clamp_high;
	always_comb begin
		gate_d[HS_POS] = want_q[2] && want_q[1];
		gate_d[LS_POS] = want_q[2] && !want_q[1];
		gate_d[HS_NEG] = want_q[2] && want_q[0];
		gate_d[LS_NEG] = want_q[2] && !want_q[0];
		gate_d = gate_d & ~oc_s2_q;
		if (clamp_now)
			gate_d = 4'hF;
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_on <= GATE_RST;
			drv_pos_out <= 1'b0;
			drv_neg_out <= 1'b0;
			drv_pos_oe <= 1'b0;
			drv_neg_oe <= 1'b0;
			clamp_all_on <= 1'b0;
		end else begin
			gate_on <= gate_d;
			drv_pos_out <= want_q[1];
			drv_neg_out <= want_q[0];
			drv_pos_oe <= want_q[2] || clamp_now;
			drv_neg_oe <= want_q[2] || clamp_now;
			clamp_all_on <= clamp_now;
		end
	end

	// Checks
	timeout_span_a: assert property (@(posedge clk) disable iff (!rst_n)
		tout_hit |-> tout_q == 14'h3FFF) else $error("timeout not at 16384");
	start_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_REST && st_d == ST_RUN) |=> tout_run_q && tout_q == 14'h0000)
		else $error("timer did not start");
	stop_move_a: assert property (@(posedge clk) disable iff (!rst_n)
		((st_q == ST_RUN || st_q == ST_PROP) && (s_zero || tout_hit) && !s_ov && !s_ot) |=> st_q == ST_BRAKE)
		else $error("motor did not stop");
	fault_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_ov || s_ot) |=> st_q == ST_OFF) else $error("fault not shut down");
	clamp_four_a: assert property (@(posedge clk) disable iff (!rst_n)
		clamp_now |=> gate_on == 4'hF) else $error("clamp not all four");
	eval_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cl_q == CL_ARMED && s_ov) |=> cl_q == CL_EVAL) else $error("timers not started");
	slow_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cl_q == CL_EVAL && eval_done && !s_clamp) |=> clamp_high) else $error("not raised");
	hold_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cl_q == CL_HOLD) |-> !clamp_high) else $error("raised during hold");
	rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cl_q == CL_RAISED && s_ov) |=> clamp_high) else $error("re-armed early");
	curr_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
		(oc_s2_q[0] && !clamp_now) |=> !gate_on[0]) else $error("limit ignored");
	brake_level_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_BRAKE && want_q == {want_oe, want_pos, want_neg}) |=> drv_pos_out && drv_neg_out)
		else $error("brake not zero differential");
	rest_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_REST && want_q == {want_oe, want_pos, want_neg}) |=> drv_pos_out && drv_neg_out && drv_pos_oe)
		else $error("rest terminals not high");
	dir_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_REST && st_d == ST_RUN) |=> dir_q == $past(s_pos))
		else $error("direction not taken from error sign");
	prop_side_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_PROP) |-> (dir_q ? want_pos : want_neg))
		else $error("proportional drive side not high");
	keep_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_PROP && !s_zero && !tout_hit && !s_ov && !s_ot) |=> (st_q == ST_PROP || st_q == ST_RUN))
		else $error("drive dropped before zero");
	overtemp_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_ot |=> st_q == ST_OFF)
		else $error("over-temperature not shut down");
	hiz_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!want_q[2] && !clamp_now) |=> !drv_pos_oe && !drv_neg_oe)
		else $error("terminals driven while off");
	switch_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(want_q) |-> $past(osc_tick) && $past(dly_q) == 2'b01)
		else $error("terminal change not on delay expiry");
endmodule // position_servo_bridge_control

// >>> rtl/servo_bridge_pkg.sv
// Constants shared by the position servo bridge control logic
package servo_bridge_pkg;
	// Clock rate
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	// Default oscillator period in clock cycles (a 1 ms period, parameterisable)
	localparam int OSC_PERIOD_US = 1000;
	localparam int OSC_CYC = (OSC_PERIOD_US * 1000) / CLK_NS;
	// Timeout counter width and span in oscillator periods
	localparam int TOUT_BITS = 14;
	localparam int TOUT_PERIODS = 16384;
	// Clamp evaluation delay and hold delay
	localparam int EVAL_US = 130;
	localparam int HOLD_US = 1000;
	localparam int EVAL_CYC = (EVAL_US * 1000) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_US * 1000) / CLK_NS;
	// Turn-on and turn-off delay in oscillator period edges
	localparam int SW_DELAY_TICKS = 2;
	// Bit order of the four bridge transistors
	localparam int HS_POS = 0;
	localparam int LS_POS = 1;
	localparam int HS_NEG = 2;
	localparam int LS_NEG = 3;
	// Reset values
	localparam logic [3:0] GATE_RST = 4'h0;
	localparam logic CLAMP_HIGH_RST = 1'b0;

	// Drive states
	typedef enum logic [4:0] {
		ST_REST = 5'b0_0001,
		ST_RUN = 5'b0_0010,
		ST_PROP = 5'b0_0100,
		ST_BRAKE = 5'b0_1000,
		ST_OFF = 5'b1_0000
	} drive_e;

	// Clamp discrimination states
	typedef enum logic [3:0] {
		CL_ARMED = 4'b0001,
		CL_EVAL = 4'b0010,
		CL_HOLD = 4'b0100,
		CL_RAISED = 4'b1000
	} clamp_e;
endpackage

// >>> testbench/motor_pot_model.sv
// Motor with feedback potentiometer and comparators facing the bridge
`timescale 1ns/100ps
module motor_pot_model #(
	parameter int REST_W = 8,
	parameter int PROP_W = 40,
	parameter int STEP_CYC = 16
) (
	// Clock
	input wire logic clk,
	// Target position and shaft stall
	input wire logic signed [15:0] cmd,
	input wire logic stall,
	// Motor terminals
	input wire logic pos_out,
	input wire logic pos_oe,
	input wire logic neg_out,
	input wire logic neg_oe,
	// Comparator results and shaft position
	output logic out_of_rest = 1'b0,
	output logic error_positive = 1'b0,
	output logic below_prop = 1'b1,
	output logic zero_cross = 1'b1,
	output logic pwm_compare = 1'b0,
	output logic signed [15:0] pos = 16'sh0000
);
	logic signed [15:0] err;
	logic [7:0] cnt_q = 8'h00;
	logic [7:0] acc_q = 8'h00;
	logic dir_q = 1'b0;
	logic outside;
	logic dir_d;
	logic diff;
	assign err = cmd - pos;
	assign outside = (err > REST_W) || (err < -REST_W);
	assign dir_d = outside ? (err > 0) : dir_q;
	// Only a driven, unequal pair of terminals turns the shaft
	assign diff = pos_oe && neg_oe && (pos_out != neg_out);
	// Shaft steps after STEP_CYC cycles of differential drive
	always @(posedge clk) begin
		cnt_q <= cnt_q + 8'h01;
		acc_q <= (diff && !stall) ? ((acc_q == STEP_CYC - 1) ? 8'h00 : acc_q + 8'h01) : acc_q;
		if (diff && !stall && acc_q == STEP_CYC - 1) begin
			pos <= pos_out ? pos + 16'sh0001 : pos - 16'sh0001;
		end
		dir_q <= dir_d;
		out_of_rest <= outside;
		error_positive <= err > 0;
		below_prop <= (err < PROP_W) && (err > -PROP_W);
		zero_cross <= dir_d ? (err <= 0) : (err >= 0);
		pwm_compare <= cnt_q[4];
	end
endmodule // motor_pot_model

// >>> testbench/tb_position_servo_bridge_control.sv
// Self-checking bench for the position servo bridge control
`timescale 1ns/100ps
module tb_position_servo_bridge_control;
	typedef struct {int id; logic [7:0] val;} note_s;
	localparam int OSC = 4;
	localparam int LIMIT = 90000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic overvoltage = 1'b0;
	logic thermal_shutdown_level = 1'b0;
	logic clamp_active = 1'b0;
	logic stall = 1'b0;
	logic [3:0] over_current = 4'h0;
	logic signed [15:0] cmd = 16'sh0000;
	logic signed [15:0] pos;
	logic out_of_rest, error_positive, below_prop, zero_cross, pwm_compare;
	logic [3:0] gate_on;
	logic drv_pos_out, drv_pos_oe, drv_neg_out, drv_neg_oe, clamp_all_on, clamp_high, timed_out;
	note_s notes[$];
	event sample_ev;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	string names[6] = '{"gate_on", "terminals", "clamp_high", "timed_out", "clamp_all_on", "settled"};
	// Free-running clock
	always #10 clk = ~clk;
	position_servo_bridge_control #(.OSC_CYCLES(OSC), .EVAL_CYCLES(10), .HOLD_CYCLES(40)) dut (
		.clk(clk), .rst_n(rst_n), .out_of_rest(out_of_rest), .error_positive(error_positive),
		.below_prop(below_prop), .zero_cross_comparator(zero_cross), .pwm_compare(pwm_compare),
		.overvoltage(overvoltage), .thermal_shutdown_level(thermal_shutdown_level),
		.clamp_active(clamp_active), .over_current(over_current), .gate_on(gate_on),
		.drv_pos_out(drv_pos_out), .drv_pos_oe(drv_pos_oe), .drv_neg_out(drv_neg_out),
		.drv_neg_oe(drv_neg_oe), .clamp_all_on(clamp_all_on), .clamp_high(clamp_high), .timed_out(timed_out));
	motor_pot_model motor (
		.clk(clk), .cmd(cmd), .stall(stall), .pos_out(drv_pos_out), .pos_oe(drv_pos_oe),
		.neg_out(drv_neg_out), .neg_oe(drv_neg_oe), .out_of_rest(out_of_rest),
		.error_positive(error_positive), .below_prop(below_prop), .zero_cross(zero_cross),
		.pwm_compare(pwm_compare), .pos(pos));
	function automatic logic [7:0] observe(int id);
		case (id)
			0: return {4'h0, gate_on};
			1: return {4'h0, drv_pos_oe, drv_pos_out, drv_neg_oe, drv_neg_out};
			2: return {7'h00, clamp_high};
			3: return {7'h00, timed_out};
			4: return {7'h00, clamp_all_on};
			default: return {7'h00, (cmd - pos <= 8) && (pos - cmd <= 8)};
		endcase
	endfunction
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("Counts: %0d checks, %0d mismatches", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic expect_now(int id, logic [7:0] val);
		notes.push_back('{id, val});
		->sample_ev;
		#0;
	endtask
	// Oldest note is compared against the outputs when a result is sampled
	always @(sample_ev) begin
		note_s n;
		n = notes.pop_front();
		check(names[n.id], observe(n.id), n.val);
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			stop_test();
		end
	end
	// Move to a target, check run polarity, then settling in rest
	task automatic move_to(logic signed [15:0] target, logic [7:0] run_terms);
		cmd = target;
		tick(30);
		expect_now(1, run_terms);
		tick(4000);
		expect_now(5, 8'h01);
		expect_now(1, 8'h0F);
		$display("Test move to %0d done", target);
	endtask
	// Main sequence
	initial begin
		void'($urandom(90));
		tick(2);
		expect_now(0, 8'h00);
		rst_n = 1'b1;
		tick(30);
		expect_now(1, 8'h0F);
		expect_now(0, 8'h05);
		$display("Test rest done");
		move_to(pos + 16'(40 + $urandom_range(59)), 8'h0E);
		move_to(pos - 16'(40 + $urandom_range(59)), 8'h0B);
		over_current = 4'h1 << $urandom_range(3);
		tick(30);
		expect_now(0, 8'h05 & ~{4'h0, over_current});
		over_current = 4'h0;
		tick(30);
		expect_now(0, 8'h05);
		thermal_shutdown_level = 1'b1;
		tick(30);
		expect_now(1, 8'h05);
		thermal_shutdown_level = 1'b0;
		overvoltage = 1'b1;
		tick(30);
		expect_now(1, 8'h05);
		expect_now(2, 8'h01);
		overvoltage = 1'b0;
		tick(10);
		expect_now(2, 8'h00);
		clamp_active = 1'b1;
		overvoltage = 1'b1;
		tick(11);
		expect_now(4, 8'h01);
		tick(9);
		expect_now(2, 8'h00);
		tick(40);
		expect_now(2, 8'h01);
		clamp_active = 1'b0;
		overvoltage = 1'b0;
		tick(40);
		expect_now(2, 8'h00);
		expect_now(1, 8'h0F);
		$display("Test protections done");
		stall = 1'b1;
		cmd = pos + 16'sh0064;
		tick(30);
		expect_now(3, 8'h00);
		tick(16384 * OSC - 100);
		expect_now(3, 8'h00);
		tick(200);
		expect_now(3, 8'h01);
		expect_now(1, 8'h0F);
		stall = 1'b0;
		cmd = pos;
		tick(30);
		move_to(pos + 16'(40 + $urandom_range(59)), 8'h0E);
		expect_now(3, 8'h00);
		$display("Test timeout done");
		stop_test();
	end
endmodule // tb_position_servo_bridge_control
